/* sauh_uart.v */
// serial port with baud timer, interrupt flag/enable registers and vector encoder
// How it works
// [R1] timer edge flag cannot set while either serial half is enabled
// [R2] timer edge flag shares the transmitter interrupt vector
// [R3] writing one clears the timer edge flag; zero leaves it
// [R4] level source sets on falling edge and stays set while input low
// [R5] edge source sets only on transition to its active polarity
// [R6] flag write of one clears by a single pulse; zero does nothing
// [R7] highest asserted enabled bit wins; second flag register ranks above first
// [R8] enabled flag interrupts; run pin rises when bus control bit3 is zero
// [R9] software sets the baud timer before enabling the serial port
// [R10] bit timing is one sixteenth of baud timer interval rate
// [R11] baud timer forced to interval mode while serial port enabled
// [R12] transmitter adds start, parity, one stop with parity, two without
// [R13] receiver needs only one stop bit in every format
// [R14] seven or eight data bits, no parity, odd or even parity
// [R15] one address: write loads transmit data, read returns receive data
// [R16] transmit interrupt on data empty or data and shift empty
// [R17] receiver splits bits in sixteen, resyncs on start, samples centre
// [R18] start abandoned if line returns high within half a bit
// [R19] error flag on parity, framing or overrun
// [R20] receive interrupt on every transfer into receive data register
// [R21] smallest divisor gives sixteen clocks per bit
// [R22] receiver and its status work only while receiver enable set
// [R23] transmit enable gates transmitter, its interrupt and pin; clearing clears source select
// [R24] seven bit mode drops transmit bit 7, receive bit 7 reads zero
// [R25] parity sense zero gives odd, one gives even over data plus parity
// [R26] error flag cleared by reset or writing one
// [R27] transmit line idles high when idle or disabled
`timescale 1ns/100ps
`include "sauh_defs.vh"
module sauh_uart #(
	parameter FIFO_DEPTH = 16,
	parameter FIFO_AW = 4
) (
	input wire CLK,
	input wire RESETN,
	input wire [7:0] ADDR,
	input wire [7:0] WDATA,
	input wire WE,
	input wire RE,
	output reg [7:0] RDATA,
	output reg TX_READY,
	input wire RXD,
	output reg TXD,
	output reg TXD_OE,
	input wire LEVEL_IRQ_N,
	input wire EDGE_IRQ,
	input wire TIMER_A_PIN,
	input wire WAIT_REQ,
	input wire BUS_CONTROL_BIT3,
	output reg IRQ_N,
	output reg [3:0] IRQ_VEC,
	output reg RUN
);
	localparam TX_IDLE = 5'b00001;
	localparam TX_START = 5'b00010;
	localparam TX_DATA = 5'b00100;
	localparam TX_PAR = 5'b01000;
	localparam TX_STOP = 5'b10000;
	localparam RX_IDLE = 4'b0001;
	localparam RX_START = 4'b0010;
	localparam RX_BITS = 4'b0100;
	localparam RX_STOP = 4'b1000;

	reg [7:0] scs_q;
	reg [7:0] irq_enables_one_q;
	reg [7:0] irq_enables_two_q;
	reg [7:0] tcr1_q;
	reg [7:0] tcr2_q;
	reg [7:0] ta_lo_q;
	reg [7:0] ta_hi_q;
	reg [15:0] ta_cnt_q;
	reg ta_flag_q;
	reg lvl_flag_q;
	reg edg_flag_q;
	reg [7:0] rdr_q;
	reg rx_full_q;
	// three-stage synchronisers for pins, stable value updates when stages 2 and 3 agree
	reg [2:0] s_rx_q;
	reg [2:0] s_lvl_q;
	reg [2:0] s_edg_q;
	reg [2:0] s_ta_q;
	reg rx_st_q;
	reg lvl_st_q;
	reg edg_st_q;
	reg ta_st_q;
	reg [4:0] tx_state_q;
	reg [3:0] tx_sub_q;
	reg [2:0] tx_bit_q;
	reg [7:0] tx_sh_q;
	reg tx_par_q;
	reg tx_stop2_q;
	reg [3:0] rx_state_q;
	reg [3:0] rx_sub_q;
	reg [3:0] rx_bit_q;
	reg [8:0] rx_sh_q;
	reg rx_err_set;
	reg rx_xfer;

	wire uart_on = scs_q[`SAUH_SCS_TXEN] | scs_q[`SAUH_SCS_RXEN];
	wire wr_scs = WE & (ADDR == `SAUH_A_SCS);
	wire wr_dat = WE & (ADDR == `SAUH_A_SDATA);
	wire rd_dat = RE & (ADDR == `SAUH_A_SDATA);
	wire wr_irq_flags_one = WE & (ADDR == `SAUH_A_IFR_ONE);
	wire wr_tcr1 = WE & (ADDR == `SAUH_A_TCR_ONE);
	wire eight = scs_q[`SAUH_SCS_WIDTH];
	wire paren = scs_q[`SAUH_SCS_PAREN];
	wire sense = scs_q[`SAUH_SCS_PARSENSE];
	wire rx_en = scs_q[`SAUH_SCS_RXEN];
	wire tx_en = scs_q[`SAUH_SCS_TXEN];

	// [R11] interval mode forced
	wire interval = uart_on | ~tcr1_q[`SAUH_TCR_TAMODE];
	wire ta_run = interval & (tcr1_q[`SAUH_TCR_TAEN] | uart_on);
	// [R10] one tick per timer interval, sixteen ticks per bit
	// [R21] divisor zero ticks on every clock
	wire tick = ta_run & (ta_cnt_q == 16'h0000);

	wire lvl_fell = lvl_st_q & ~s_lvl_q[2] & (s_lvl_q[1] == s_lvl_q[2]);
	wire edg_rose = ~edg_st_q & s_edg_q[2] & (s_edg_q[1] == s_edg_q[2]);
	wire ta_rose = ~ta_st_q & s_ta_q[2] & (s_ta_q[1] == s_ta_q[2]);

	// transmit fifo acts as the transmit data register
	wire [7:0] fifo_out;
	wire fifo_valid;
	wire fifo_ready;
	wire tx_take = (tx_state_q == TX_IDLE) & tx_en & fifo_valid & tick;
	// [R15] write side of the shared data address; full fifo refuses the write
	// [R24] bit 7 dropped in seven bit mode
	sauh_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_txf (
		.clk(CLK),
		.resetn(RESETN),
		.in_valid(wr_dat & tx_en),
		.in_ready(fifo_ready),
		.in_data({WDATA[7] & eight, WDATA[6:0]}),
		.out_valid(fifo_valid),
		.out_ready(tx_take),
		.out_data(fifo_out)
	);

	wire tx_busy = (tx_state_q != TX_IDLE);
	// [R16] source select chooses end of byte or end of message
	// [R23] transmit interrupt only while transmitter enabled
	wire tx_irq = tx_en & (scs_q[`SAUH_SCS_TXSRC] ? (~fifo_valid & ~tx_busy) : ~fifo_valid);
	// [R2] timer edge flag rides on the transmitter vector bit
	wire [7:0] irq_flags_one = {6'h00, edg_flag_q, lvl_flag_q};
	wire [7:0] irq_flags_two = {tx_irq | ta_flag_q, rx_full_q, 6'h00};
	wire [15:0] pend = {irq_flags_two & irq_enables_two_q, irq_flags_one & irq_enables_one_q};
	reg [3:0] vec;
	integer i;
	// [R7] highest bit wins, second register above first
	always @* begin
		vec = 4'h0;
		for (i = 0; i < 16; i = i + 1) begin
			if (pend[i])
				vec = i[3:0];
		end
	end

	// receive parity over the received data bits
	wire [7:0] rx_data = eight ? rx_sh_q[7:0] : {1'b0, rx_sh_q[6:0]};
	wire rx_par_bit = eight ? rx_sh_q[8] : rx_sh_q[7];
	// index of the last bit before stop: six, plus one for eight bits, plus one for parity
	wire [3:0] rx_nbits = 4'h6 + {3'h0, eight} + {3'h0, paren};

	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			s_rx_q <= 3'h7;
			s_lvl_q <= 3'h7;
			s_edg_q <= 3'h0;
			s_ta_q <= 3'h0;
			rx_st_q <= 1'b1;
			lvl_st_q <= 1'b1;
			edg_st_q <= 1'b0;
			ta_st_q <= 1'b0;
		end else begin
			s_rx_q <= {s_rx_q[1:0], RXD};
			s_lvl_q <= {s_lvl_q[1:0], LEVEL_IRQ_N};
			s_edg_q <= {s_edg_q[1:0], EDGE_IRQ};
			s_ta_q <= {s_ta_q[1:0], TIMER_A_PIN};
			if (s_rx_q[1] == s_rx_q[2])
				rx_st_q <= s_rx_q[2];
			if (s_lvl_q[1] == s_lvl_q[2])
				lvl_st_q <= s_lvl_q[2];
			if (s_edg_q[1] == s_edg_q[2])
				edg_st_q <= s_edg_q[2];
			if (s_ta_q[1] == s_ta_q[2])
				ta_st_q <= s_ta_q[2];
		end
	end

	// register file, flags and timer
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			scs_q <= `SAUH_REG_RESET;
			irq_enables_one_q <= `SAUH_REG_RESET;
			irq_enables_two_q <= `SAUH_REG_RESET;
			tcr1_q <= `SAUH_REG_RESET;
			tcr2_q <= `SAUH_REG_RESET;
			ta_lo_q <= `SAUH_REG_RESET;
			ta_hi_q <= `SAUH_REG_RESET;
			ta_cnt_q <= `SAUH_TA_RESET;
			ta_flag_q <= 1'b0;
			lvl_flag_q <= 1'b0;
			edg_flag_q <= 1'b0;
		end else begin
			if (wr_scs) begin
				scs_q[6:0] <= WDATA[6:0];
				// [R23] disabling the transmitter clears source select
				if (!WDATA[`SAUH_SCS_TXEN])
					scs_q[`SAUH_SCS_TXSRC] <= 1'b0;
			end
			// [R19] parity, framing or overrun sets error; set wins over clear
			// [R26] write one clears error flag
			if (rx_err_set)
				scs_q[`SAUH_SCS_RXERR] <= 1'b1;
			else if (wr_scs & WDATA[`SAUH_SCS_RXERR])
				scs_q[`SAUH_SCS_RXERR] <= 1'b0;
			if (WE & (ADDR == `SAUH_A_IER_ONE))
				irq_enables_one_q <= WDATA;
			if (WE & (ADDR == `SAUH_A_IER_TWO))
				irq_enables_two_q <= WDATA;
			if (wr_tcr1)
				tcr1_q <= {1'b0, WDATA[6:0]};
			if (WE & (ADDR == `SAUH_A_TCR_TWO))
				tcr2_q <= WDATA;
			if (WE & (ADDR == `SAUH_A_TA_LO))
				ta_lo_q <= WDATA;
			// hi write loads the counter from both latches
			if (WE & (ADDR == `SAUH_A_TA_HI)) begin
				ta_hi_q <= WDATA;
				ta_cnt_q <= {WDATA, ta_lo_q};
			end else if (ta_run) begin
				ta_cnt_q <= tick ? {ta_hi_q, ta_lo_q} : ta_cnt_q - 16'h0001;
			end
			// [R1] edge flag blocked while serial port runs
			// [R3] write one clears, zero ignored; new edge wins
			if (ta_rose & ~uart_on & ~interval)
				ta_flag_q <= 1'b1;
			else if (wr_tcr1 & WDATA[`SAUH_TCR_TAFLAG])
				ta_flag_q <= 1'b0;
			// [R4] set on falling edge, held while input stays low
			// [R6] one-cycle clear pulse, never held cleared
			lvl_flag_q <= lvl_fell | (lvl_flag_q & (~lvl_st_q | ~(wr_irq_flags_one & WDATA[`SAUH_IRQ_FLAGS_ONE_LEVEL])));
			// [R5] only a rising transition sets the edge flag
			edg_flag_q <= edg_rose | (edg_flag_q & ~(wr_irq_flags_one & WDATA[`SAUH_IRQ_FLAGS_ONE_EDGE]));
		end
	end

	// transmitter
	wire tx_bit_done = tick & (tx_sub_q == `SAUH_LAST_SUB);
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			tx_state_q <= TX_IDLE;
			tx_sub_q <= 4'h0;
			tx_bit_q <= 3'h0;
			tx_sh_q <= 8'h00;
			tx_par_q <= 1'b0;
			tx_stop2_q <= 1'b0;
			TXD <= 1'b1;
		end else if (!tx_en) begin
			// [R27] disabled transmitter holds the line high
			tx_state_q <= TX_IDLE;
			tx_sub_q <= 4'h0;
			TXD <= 1'b1;
		end else begin
			if (tick)
				tx_sub_q <= tx_sub_q + 4'h1;
			case (tx_state_q)
			TX_IDLE: begin
				TXD <= 1'b1;
				if (tx_take) begin
					// [R12] start bit added automatically
					tx_state_q <= TX_START;
					tx_sh_q <= fifo_out;
					// [R25] odd parity when sense is zero
					tx_par_q <= sense ? ^fifo_out : ~^fifo_out;
					tx_sub_q <= 4'h0;
					tx_bit_q <= eight ? 3'h7 : 3'h6;
					TXD <= 1'b0;
				end
			end
			TX_START: begin
				if (tx_bit_done) begin
					tx_state_q <= TX_DATA;
					TXD <= tx_sh_q[0];
					tx_sh_q <= {1'b0, tx_sh_q[7:1]};
				end
			end
			TX_DATA: begin
				if (tx_bit_done) begin
					if (tx_bit_q != 3'h0) begin
						TXD <= tx_sh_q[0];
						tx_sh_q <= {1'b0, tx_sh_q[7:1]};
						tx_bit_q <= tx_bit_q - 3'h1;
					end else if (paren) begin
						tx_state_q <= TX_PAR;
						TXD <= tx_par_q;
					end else begin
						// [R12] two stop bits without parity
						tx_state_q <= TX_STOP;
						tx_stop2_q <= 1'b1;
						TXD <= 1'b1;
					end
				end
			end
			TX_PAR: begin
				if (tx_bit_done) begin
					tx_state_q <= TX_STOP;
					tx_stop2_q <= 1'b0;
					TXD <= 1'b1;
				end
			end
			TX_STOP: begin
				if (tx_bit_done) begin
					if (tx_stop2_q)
						tx_stop2_q <= 1'b0;
					else
						tx_state_q <= TX_IDLE;
				end
			end
			default: begin
				tx_state_q <= TX_IDLE;
				TXD <= 1'b1;
			end
			endcase
		end
	end

	// receiver
	always @* begin
		rx_xfer = 1'b0;
		rx_err_set = 1'b0;
		// [R13] a single stop bit completes the character
		if ((rx_state_q == RX_STOP) & tick & (rx_sub_q == `SAUH_LAST_SUB) & rx_en) begin
			rx_xfer = 1'b1;
			// [R25] parity checked over data plus parity bit
			rx_err_set = ~rx_st_q | rx_full_q | (paren & ((^rx_data ^ rx_par_bit) == sense));
		end
	end

	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			rx_state_q <= RX_IDLE;
			rx_sub_q <= 4'h0;
			rx_bit_q <= 4'h0;
			rx_sh_q <= 9'h000;
			rdr_q <= 8'h00;
			rx_full_q <= 1'b0;
		end else if (!rx_en) begin
			// [R22] disabled receiver clears its logic and rdr bit 7
			rx_state_q <= RX_IDLE;
			rx_sub_q <= 4'h0;
			rx_full_q <= 1'b0;
			rdr_q[7] <= 1'b0;
		end else begin
			if (tick)
				rx_sub_q <= rx_sub_q + 4'h1;
			// [R20] transfer raises receive flag; new transfer beats a read
			if (rx_xfer) begin
				rdr_q <= rx_data;
				rx_full_q <= 1'b1;
			end else if (rd_dat) begin
				rx_full_q <= 1'b0;
			end
			case (rx_state_q)
			RX_IDLE: begin
				if (!rx_st_q) begin
					rx_state_q <= RX_START;
					rx_sub_q <= 4'h0;
				end
			end
			RX_START: begin
				// [R18] glitch shorter than half a bit is dropped
				if (rx_st_q) begin
					rx_state_q <= RX_IDLE;
				end else if (tick & (rx_sub_q == `SAUH_HALF_BIT - 4'h1)) begin
					// [R17] resync to start centre, then sample every sixteen ticks
					rx_state_q <= RX_BITS;
					rx_sub_q <= 4'h0;
					rx_bit_q <= 4'h0;
				end
			end
			RX_BITS: begin
				if (tick & (rx_sub_q == `SAUH_LAST_SUB)) begin
					// [R14] seven or eight bits plus optional parity
					rx_sh_q[rx_bit_q] <= rx_st_q;
					rx_bit_q <= rx_bit_q + 4'h1;
					if (rx_bit_q == rx_nbits)
						rx_state_q <= RX_STOP;
				end
			end
			RX_STOP: begin
				if (tick & (rx_sub_q == `SAUH_LAST_SUB))
					rx_state_q <= RX_IDLE;
			end
			default: rx_state_q <= RX_IDLE;
			endcase
		end
	end

	// registered outputs: read data, interrupt request, vector, run pin
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			RDATA <= 8'h00;
			TX_READY <= 1'b0;
			TXD_OE <= 1'b0;
			IRQ_N <= 1'b1;
			IRQ_VEC <= 4'h0;
			RUN <= 1'b1;
		end else begin
			TX_READY <= fifo_ready & tx_en;
			// [R23] pin driven only while transmitter enabled
			TXD_OE <= tx_en;
			// [R8] any enabled flag requests the processor
			IRQ_N <= ~(|pend);
			IRQ_VEC <= vec;
			if ((|pend) & ~BUS_CONTROL_BIT3)
				RUN <= 1'b1;
			else if (WAIT_REQ)
				RUN <= 1'b0;
			case (ADDR)
			`SAUH_A_IFR_ONE: RDATA <= irq_flags_one;
			`SAUH_A_IER_ONE: RDATA <= irq_enables_one_q;
			`SAUH_A_IFR_TWO: RDATA <= irq_flags_two;
			`SAUH_A_IER_TWO: RDATA <= irq_enables_two_q;
			`SAUH_A_TCR_ONE: RDATA <= {ta_flag_q, tcr1_q[6:0]};
			`SAUH_A_TCR_TWO: RDATA <= tcr2_q;
			`SAUH_A_SCS: RDATA <= scs_q;
			// [R15] read side of the shared data address
			// [R24] bit 7 reads zero in seven bit mode
			`SAUH_A_SDATA: RDATA <= {rdr_q[7] & eight, rdr_q[6:0]};
			`SAUH_A_TA_LO: RDATA <= ta_cnt_q[7:0];
			`SAUH_A_TA_HI: RDATA <= ta_cnt_q[15:8];
			default: RDATA <= 8'h00;
			endcase
		end
	end
endmodule

/* sauh_defs.vh */
// register offsets, field positions and reset values for the serial port block
`ifndef SAUH_DEFS_VH
`define SAUH_DEFS_VH
`define SAUH_A_IFR_TWO 8'h08
`define SAUH_A_IER_TWO 8'h09
`define SAUH_A_TCR_ONE 8'h0a
`define SAUH_A_TCR_TWO 8'h0b
`define SAUH_A_SCS 8'h22
`define SAUH_A_SDATA 8'h23
`define SAUH_A_TA_LO 8'h24
`define SAUH_A_TA_HI 8'h25
`define SAUH_A_IFR_ONE 8'h2c
`define SAUH_A_IER_ONE 8'h2d
`define SAUH_SCS_TXEN 0
`define SAUH_SCS_TXSRC 1
`define SAUH_SCS_WIDTH 2
`define SAUH_SCS_PAREN 3
`define SAUH_SCS_PARSENSE 4
`define SAUH_SCS_RXEN 5
`define SAUH_SCS_SEM 6
`define SAUH_SCS_RXERR 7
`define SAUH_TCR_TAEN 0
`define SAUH_TCR_TAMODE 1
`define SAUH_TCR_TAFLAG 7
`define SAUH_IRQ_FLAGS_ONE_LEVEL 0
`define SAUH_IRQ_FLAGS_ONE_EDGE 1
`define SAUH_IRQ_FLAGS_TWO_RX 6
`define SAUH_IRQ_FLAGS_TWO_TX 7
`define SAUH_TA_RESET 16'h0000
`define SAUH_REG_RESET 8'h00
`define SAUH_SUBTICKS 5'd16
`define SAUH_HALF_BIT 4'd8
`define SAUH_LAST_SUB 4'hf
`endif

/* sauh_fifo.v */
// parameterised synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module sauh_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire clk,
	input wire resetn,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_q;
	reg [AW-1:0] rd_q;
	reg [AW:0] cnt_q;
	wire push;
	wire pop;
	assign in_ready = (cnt_q != DEPTH[AW:0]);
	assign out_valid = (cnt_q != {(AW+1){1'b0}});
	assign out_data = mem[rd_q];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	always @(posedge clk) begin
		if (push)
			mem[wr_q] <= in_data;
	end
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
			if (push & ~pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop & ~push)
				cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule

/* sauh_uart_props.sv */
// concurrent checks on the serial port top-level ports
`timescale 1ns/100ps
module sauh_uart_props (
	input wire CLK,
	input wire RESETN,
	input wire [7:0] ADDR,
	input wire [7:0] WDATA,
	input wire WE,
	input wire TX_READY,
	input wire TXD,
	input wire TXD_OE,
	input wire LEVEL_IRQ_N,
	input wire EDGE_IRQ,
	input wire WAIT_REQ,
	input wire BUS_CONTROL_BIT3,
	input wire IRQ_N,
	input wire [3:0] IRQ_VEC,
	input wire RUN
);
	reg [7:0] ie1_q;
	reg [7:0] ie2_q;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);
	// shadow copies of the enables, so a vector can be tied to one source
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			ie1_q <= 8'h00;
			ie2_q <= 8'h00;
		end else if (WE && ADDR == 8'h2d) begin
			ie1_q <= WDATA;
		end else if (WE && ADDR == 8'h09) begin
			ie2_q <= WDATA;
		end
	end
	property p_idle;
		!TXD_OE && !$past(TXD_OE) |-> TXD;
	endproperty
	a_idle: assert property (p_idle) else $error("line low while disabled");
	property p_oe;
		WE && ADDR == 8'h22 |-> ##2 (TXD_OE == $past(WDATA[0], 2));
	endproperty
	a_oe: assert property (p_oe) else $error("pin enable not following control");
	property p_rdy;
		!TXD_OE && !$past(TXD_OE) |-> !TX_READY;
	endproperty
	a_rdy: assert property (p_rdy) else $error("ready while disabled");
	property p_lvl;
		!LEVEL_IRQ_N [*8] ##0 (ie1_q == 8'h01 && ie2_q == 8'h00) |=> !IRQ_N && IRQ_VEC == 4'h0;
	endproperty
	a_lvl: assert property (p_lvl) else $error("level source not pending");
	property p_edge;
		$rose(EDGE_IRQ) && ie1_q == 8'h02 && ie2_q == 8'h00 |-> ##[2:8] (!IRQ_N && IRQ_VEC == 4'h1);
	endproperty
	a_edge: assert property (p_edge) else $error("edge source not pending");
	property p_w1c;
		EDGE_IRQ [*8] ##0 (WE && ADDR == 8'h2c && WDATA[1] && ie1_q == 8'h02 && ie2_q == 8'h00)
			|-> ##[1:3] IRQ_N;
	endproperty
	a_w1c: assert property (p_w1c) else $error("flag not cleared by write");
	property p_run;
		!IRQ_N && !BUS_CONTROL_BIT3 && !WAIT_REQ |=> RUN;
	endproperty
	a_run: assert property (p_run) else $error("run pin low with pending request");
	property p_bit;
		$fell(TXD) |-> !TXD [*8] ##1 !TXD [*8];
	endproperty
	a_bit: assert property (p_bit) else $error("bit shorter than sixteen ticks");
endmodule

/* sauh_peer.sv */
// behavioural remote serial port: records the block's line, sends frames back
`timescale 1ns/100ps
module sauh_peer #(
	parameter BT = 16
) (
	input wire clk,
	input wire txd,
	output reg rxd,
	output reg [23:0] cap,
	output reg [31:0] cnt
);
	integer k;
	initial begin
		rxd = 1'b1;
		cap = 24'h0;
		cnt = 0;
		forever begin
			@(negedge txd);
			repeat (BT / 2) @(posedge clk);
			for (k = 0; k < 24; k = k + 1) begin
				cap[k] = txd;
				repeat (BT) @(posedge clk);
			end
			cnt = cnt + 1;
		end
	end
	// one stop bit only, then mark level
	task send(input [10:0] b, input integer n);
		integer j;
		begin
			@(posedge clk);
			for (j = 0; j < n; j = j + 1) begin
				rxd <= b[j];
				repeat (BT) @(posedge clk);
			end
		end
	endtask
	// low pulse far shorter than half a bit
	task blip;
		begin
			rxd <= 1'b0;
			repeat (BT / 4) @(posedge clk);
			rxd <= 1'b1;
		end
	endtask
endmodule

/* sauh_uart_tb.sv */
// self-checking bench for the serial port block
`timescale 1ns/100ps
module sauh_uart_tb;
	reg CLK = 1'b0;
	reg RESETN = 1'b0;
	reg [7:0] ADDR = 8'h00;
	reg [7:0] WDATA = 8'h00;
	reg WE = 1'b0, RE = 1'b0, LEVEL_IRQ_N = 1'b1, EDGE_IRQ = 1'b0;
	reg TIMER_A_PIN = 1'b0, WAIT_REQ = 1'b0, BUS_CONTROL_BIT3 = 1'b0;
	wire [7:0] RDATA;
	wire [3:0] IRQ_VEC;
	wire [23:0] cap;
	wire [31:0] cnt;
	wire TX_READY, RXD, TXD, TXD_OE, IRQ_N, RUN;
	reg [31:0] c0;
	reg [10:0] a, b;
	integer bad_count = 0, checks = 0, cyc = 0, i;
	sauh_uart sauh_uart_inst (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WE(WE), .RE(RE),
		.RDATA(RDATA), .TX_READY(TX_READY), .RXD(RXD), .TXD(TXD), .TXD_OE(TXD_OE), .LEVEL_IRQ_N(LEVEL_IRQ_N),
		.EDGE_IRQ(EDGE_IRQ), .TIMER_A_PIN(TIMER_A_PIN), .WAIT_REQ(WAIT_REQ),
		.BUS_CONTROL_BIT3(BUS_CONTROL_BIT3), .IRQ_N(IRQ_N), .IRQ_VEC(IRQ_VEC), .RUN(RUN));
	sauh_peer #(.BT(16)) sauh_peer_inst (.clk(CLK), .txd(TXD), .rxd(RXD), .cap(cap), .cnt(cnt));
	initial forever #2.5 CLK = ~CLK;
	task wrap_up;
		begin
			$display("checks %0d bad_count %0d", checks, bad_count);
			if (bad_count == 0 && checks > 0) $display("NO MISMATCHES");
			else $display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	// cycle ceiling; the full sequence needs well under half of it
	always @(posedge CLK) begin
		cyc = cyc + 1;
		if (cyc == 30000) begin
			bad_count = bad_count + 1;
			wrap_up;
		end
	end
	task chk(input [23:0] g, input [23:0] e);
		begin
			checks = checks + 1;
			if (g !== e) begin
				bad_count = bad_count + 1;
				$display("unexpected at %0t: got %h expected %h", $time, g, e);
			end
		end
	endtask
	task tk(input integer n);
		repeat (n) @(posedge CLK);
	endtask
	task wr(input [7:0] ad, input [7:0] d);
		begin
			@(posedge CLK);
			ADDR <= ad;
			WDATA <= d;
			WE <= 1'b1;
			@(posedge CLK);
			WE <= 1'b0;
		end
	endtask
	task rd(input [7:0] ad, input [7:0] e);
		begin
			@(posedge CLK);
			ADDR <= ad;
			RE <= 1'b1;
			@(posedge CLK);
			RE <= 1'b0;
			#1 chk({16'h0, RDATA}, {16'h0, e});
		end
	endtask
	task wcap;
		for (i = 0; i < 3000 && cnt == c0; i = i + 1) @(posedge CLK);
	endtask
	function [10:0] fr(input [7:0] d, input w8, input pe, input ev);
		reg [7:0] x;
		reg q;
		begin
			x = w8 ? d : {1'b0, d[6:0]};
			q = pe ? (^x ^ !ev) : 1'b1;
			fr = w8 ? {1'b1, q, x, 1'b0} : {2'b11, q, x[6:0], 1'b0};
		end
	endfunction
	task t_reset;
		begin
			rd(8'h22, 8'h00);
			rd(8'h2c, 8'h00);
			rd(8'h08, 8'h00);
			rd(8'h77, 8'h00);
			chk({22'h0, TXD, TXD_OE}, 24'h2);
		end
	endtask
	task t_tx8;
		begin
			wr(8'h24, 8'h00);
			wr(8'h25, 8'h00);
			wr(8'h0a, 8'h01);
			wr(8'h22, 8'h05);
			c0 = cnt;
			wr(8'h23, 8'ha5);
			wr(8'h23, 8'h3c);
			for (i = 0; i < 16; i = i + 1) wr(8'h23, 8'h00);
			tk(2);
			#1 chk({23'h0, TX_READY}, 24'h0);
			a = fr(8'ha5, 1, 0, 0);
			b = fr(8'h3c, 1, 0, 0);
			wcap;
			chk(cap, {2'b00, b, a});
			tk(3400);
			rd(8'h08, 8'h80);
		end
	endtask
	task t_tx7;
		begin
			wr(8'h22, 8'h1b);
			c0 = cnt;
			wr(8'h23, 8'hff);
			wr(8'h23, 8'h80);
			rd(8'h08, 8'h00);
			a = fr(8'hff, 0, 1, 1);
			b = fr(8'h80, 0, 1, 1);
			wcap;
			chk(cap, {4'hf, b[9:0], a[9:0]});
			rd(8'h08, 8'h80);
			wr(8'h22, 8'h1a);
			rd(8'h22, 8'h18);
		end
	endtask
	task t_rx;
		begin
			wr(8'h22, 8'h2c);
			sauh_peer_inst.send(fr(8'h3c, 1, 1, 0), 11);
			tk(4);
			rd(8'h08, 8'h40);
			rd(8'h23, 8'h3c);
			rd(8'h08, 8'h00);
			sauh_peer_inst.send(fr(8'h3c, 1, 1, 0) ^ 11'h200, 11);
			tk(4);
			rd(8'h22, 8'hac);
			wr(8'h22, 8'h2c);
			rd(8'h22, 8'hac);
			wr(8'h22, 8'hac);
			rd(8'h22, 8'h2c);
			sauh_peer_inst.send(fr(8'h5a, 1, 1, 0), 11);
			tk(4);
			rd(8'h22, 8'hac);
			rd(8'h23, 8'h5a);
			wr(8'h22, 8'ha4);
			sauh_peer_inst.send(fr(8'h81, 1, 0, 0), 10);
			tk(4);
			rd(8'h23, 8'h81);
			wr(8'h22, 8'h20);
			rd(8'h23, 8'h01);
			sauh_peer_inst.send(fr(8'h55, 0, 0, 0), 9);
			tk(4);
			rd(8'h23, 8'h55);
			@(posedge CLK);
			sauh_peer_inst.blip;
			tk(300);
			rd(8'h08, 8'h00);
			wr(8'h22, 8'h00);
			sauh_peer_inst.send(fr(8'h42, 1, 0, 0), 10);
			tk(4);
			rd(8'h08, 8'h00);
		end
	endtask
	task t_irq;
		begin
			wr(8'h2d, 8'h01);
			LEVEL_IRQ_N <= 1'b0;
			tk(10);
			#1 chk({19'h0, IRQ_N, IRQ_VEC}, 24'h0);
			wr(8'h2c, 8'h01);
			rd(8'h2c, 8'h01);
			@(posedge CLK) LEVEL_IRQ_N <= 1'b1;
			tk(4);
			wr(8'h2c, 8'h01);
			rd(8'h2c, 8'h00);
			wr(8'h2d, 8'h02);
			WAIT_REQ <= 1'b1;
			tk(3);
			#1 chk({23'h0, RUN}, 24'h0);
			@(posedge CLK) WAIT_REQ <= 1'b0;
			EDGE_IRQ <= 1'b1;
			tk(10);
			#1 chk({18'h0, RUN, IRQ_N, IRQ_VEC}, 24'h21);
			BUS_CONTROL_BIT3 <= 1'b1;
			WAIT_REQ <= 1'b1;
			tk(3);
			#1 chk({23'h0, RUN}, 24'h0);
			@(posedge CLK) WAIT_REQ <= 1'b0;
			BUS_CONTROL_BIT3 <= 1'b0;
			tk(2);
			#1 chk({23'h0, RUN}, 24'h1);
			wr(8'h2c, 8'h00);
			rd(8'h2c, 8'h02);
			wr(8'h2c, 8'h02);
			tk(4);
			rd(8'h2c, 8'h00);
			@(posedge CLK) EDGE_IRQ <= 1'b0;
		end
	endtask
	task t_timer;
		begin
			wr(8'h09, 8'h80);
			wr(8'h0a, 8'h03);
			wr(8'h22, 8'h20);
			TIMER_A_PIN <= 1'b1;
			tk(8);
			TIMER_A_PIN <= 1'b0;
			rd(8'h08, 8'h00);
			wr(8'h22, 8'h00);
			TIMER_A_PIN <= 1'b1;
			EDGE_IRQ <= 1'b1;
			tk(10);
			#1 chk({19'h0, IRQ_N, IRQ_VEC}, 24'h0f);
			rd(8'h08, 8'h80);
			wr(8'h0a, 8'h03);
			rd(8'h08, 8'h80);
			wr(8'h0a, 8'h83);
			rd(8'h08, 8'h00);
		end
	endtask
	initial begin
		tk(2);
		RESETN <= 1'b1;
		t_reset;
		t_tx8;
		t_tx7;
		t_rx;
		t_irq;
		t_timer;
		wrap_up;
	end
endmodule
bind sauh_uart sauh_uart_props sauh_uart_props_inst (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA),
	.WE(WE), .TX_READY(TX_READY), .TXD(TXD), .TXD_OE(TXD_OE), .LEVEL_IRQ_N(LEVEL_IRQ_N), .EDGE_IRQ(EDGE_IRQ),
	.WAIT_REQ(WAIT_REQ), .BUS_CONTROL_BIT3(BUS_CONTROL_BIT3), .IRQ_N(IRQ_N), .IRQ_VEC(IRQ_VEC), .RUN(RUN));
